// ### hub_host.sv
// Host-side model that issues memory accesses for decode
`timescale 1ns/1ps

module hub_host
    import window_decode_pkg::*;
(
    input  wire logic     clk_i,
    output logic          req_valid_o,
    output mem_req_s      req_o,
    input  wire logic     dec_valid_i,
    input  wire mem_dec_s dec_i
);
    // ========================================================================
    // Idle request lines at time zero
    initial
    begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end

    // One access: present for one edge, then collect the answer
    task automatic send(input logic [63:0] a, input logic w,
                        output mem_dec_s d, output logic ok);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o       <= '{addr: a, write: w};
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_o       <= '{addr: ~a, write: ~w}; // No stale address left
        @(posedge clk_i);
        ok = (dec_valid_i === 1'b1);
        d  = dec_i;
    endtask
endmodule // hub_host

// ### window_decode.sv
// Memory window decode and secondary status registers behind Wishbone
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps

module window_decode
    import window_decode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Hub-side memory access to decode
    input  wire logic        req_valid_i,
    input  wire mem_req_s    req_i,
    output logic             dec_valid_o,
    output mem_dec_s         dec_o,
    // Secondary bus parity sources
    input  wire logic        initiator_i,
    input  wire logic        perr_n_i,
    input  wire logic        int_parity_err_i,
    // Interrupt
    output logic             irq_o
);

    // ========================================================================
    // Decoding helpers
    function automatic logic [7:0] reg_index(input logic [9:0] adr);
        reg_index = adr[9:2];
    endfunction

    function automatic logic [15:0] win_word(input logic [11:0] f,
                                             input logic [3:0]  low);
        win_word = {f, low};
    endfunction

    // ========================================================================
    // State
    logic [WIN_W-1:0]   np_base;
    logic [WIN_W-1:0]   np_limit;
    logic [WIN_W-1:0]   pf_base;
    logic [WIN_W-1:0]   pf_top;
    logic [UPPER_W-1:0] pf_upper;
    logic               perr_resp_en;
    logic               dpe_flag;
    logic [EV_W-1:0]    evt_status;
    logic [EV_W-1:0]    evt_mask;
    logic [2:0]         perr_sync;
    logic               perr_seen;
    logic [7:0]         idx;
    logic               wr_req;
    logic               rd_req;
    logic               lo_lane;
    logic               hi_lane;
    logic [15:0]        sec_status;
    logic [HUB_ADDR_W-1:0] pf_lo_full;
    logic [HUB_ADDR_W-1:0] pf_hi_full;
    logic [31:0]        np_lo_full;
    logic [31:0]        np_hi_full;
    logic               in_np;
    logic               in_pf;
    logic               parity_set;
    logic [EV_W-1:0]    events;
    logic [31:0]        next_rd;

    // Bus request qualifiers
    assign idx     = reg_index(wb_adr_i);
    assign wr_req  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_req  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign lo_lane = wb_sel_i[0];
    assign hi_lane = wb_sel_i[1];

    // ========================================================================
    // Parity error pin, three stages, level taken when last two agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            perr_sync <= 3'h7;
        else
            perr_sync <= {perr_sync[1:0], perr_n_i};
    end

    // Filtered asserted level of the active-low pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            perr_seen <= 1'b0;
        else if (perr_sync[1] == perr_sync[2])
            perr_seen <= !perr_sync[2];
    end

    // ========================================================================
    // Window registers, only the 12-bit fields hold state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            np_base  <= WIN_RESET;
            np_limit <= WIN_RESET;
            pf_base  <= WIN_RESET;
            pf_top   <= WIN_RESET;
        end
        else if (wr_req)
        begin
            if (idx == IDX_NP_BASE)
            begin
                if (lo_lane) np_base[3:0]  <= wb_dat_i[7:4];
                if (hi_lane) np_base[11:4] <= wb_dat_i[15:8];
            end
            if (idx == IDX_NP_LIMIT)
            begin
                if (lo_lane) np_limit[3:0]  <= wb_dat_i[7:4];
                if (hi_lane) np_limit[11:4] <= wb_dat_i[15:8];
            end
            if (idx == IDX_PF_BASE)
            begin
                if (lo_lane) pf_base[3:0]  <= wb_dat_i[7:4];
                if (hi_lane) pf_base[11:4] <= wb_dat_i[15:8];
            end
            if (idx == IDX_PF_TOP)
            begin
                if (lo_lane) pf_top[3:0]  <= wb_dat_i[7:4];
                if (hi_lane) pf_top[11:4] <= wb_dat_i[15:8];
            end
        end
    end

    // Prefetchable upper address bits and bridge control
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pf_upper     <= WIN_RESET;
            perr_resp_en <= 1'b0;
        end
        else if (wr_req)
        begin
            if (idx == IDX_PF_UPPER)
            begin
                if (lo_lane) pf_upper[7:0]  <= wb_dat_i[7:0];
                if (hi_lane) pf_upper[11:8] <= wb_dat_i[11:8];
            end
            if (idx == IDX_BRIDGE_CTL && lo_lane)
                perr_resp_en <= wb_dat_i[PERR_EN_BIT];
        end
    end

    // ========================================================================
    // Data parity error flag, set wins over write-one clear
    assign parity_set = initiator_i && (perr_seen || int_parity_err_i)
                        && perr_resp_en;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dpe_flag <= 1'b0;
        else if (parity_set)
            dpe_flag <= 1'b1;
        else if (wr_req && idx == IDX_SEC_STATUS && hi_lane
                 && wb_dat_i[DPE_BIT])
            dpe_flag <= 1'b0;
    end

    // Status word, fixed fields and reserved zeros
    always_comb
    begin
        sec_status = 16'h0000;
        sec_status[DEVSEL_MSB:DEVSEL_LSB] = DEVSEL_MEDIUM;
        sec_status[DPE_BIT]   = dpe_flag;
        sec_status[FBB_BIT]   = FBB_VAL;
        sec_status[CAP66_BIT] = CAP66_VAL;
    end

    // ========================================================================
    // Window bounds at full width
    assign np_lo_full = {np_base, LOW_ZEROS};
    assign np_hi_full = {np_limit, LOW_ONES};
    assign pf_lo_full = {UPPER_PAD, pf_upper, pf_base, LOW_ZEROS};
    assign pf_hi_full = {UPPER_PAD, pf_upper, pf_top, LOW_ONES};

    // Inclusive compares
    assign in_np = (req_i.addr[63:32] == HIGH_ZERO)
                   && (req_i.addr[31:0] >= np_lo_full)
                   && (req_i.addr[31:0] <= np_hi_full);
    assign in_pf = (req_i.addr >= pf_lo_full)
                   && (req_i.addr <= pf_hi_full);

    // Registered decode answer, one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dec_valid_o <= 1'b0;
            dec_o       <= '0;
        end
        else
        begin
            dec_valid_o <= req_valid_i;
            if (req_valid_i)
            begin
                dec_o.hit_np  <= in_np;
                dec_o.hit_pf  <= in_pf;
                dec_o.forward <= in_np || in_pf;
                dec_o.write   <= req_i.write;
            end
        end
    end

    // ========================================================================
    // Interrupt events, sticky with write-one clear, set wins
    always_comb
    begin
        events = '0;
        events[EV_PARITY] = parity_set && !dpe_flag;
        events[EV_NP_HIT] = req_valid_i && in_np;
        events[EV_PF_HIT] = req_valid_i && in_pf;
        events[EV_MISS]   = req_valid_i && !in_np && !in_pf;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            evt_status <= '0;
        else if (wr_req && idx == IDX_EVT_STATUS && lo_lane)
            evt_status <= (evt_status & ~wb_dat_i[EV_W-1:0]) | events;
        else
            evt_status <= evt_status | events;
    end

    // Mask register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            evt_mask <= '0;
        else if (wr_req && idx == IDX_EVT_MASK && lo_lane)
            evt_mask <= wb_dat_i[EV_W-1:0];
    end

    // Level interrupt from a flip-flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(evt_status & evt_mask);
    end

    // ========================================================================
    // Read multiplexer, unmapped reads return zero
    always_comb
    begin
        next_rd = 32'h00000000;
        unique case (idx)
            IDX_SEC_STATUS: next_rd[15:0] = sec_status;
            IDX_NP_BASE:    next_rd[15:0] = win_word(np_base, 4'h0);
            IDX_NP_LIMIT:   next_rd[15:0] = win_word(np_limit, 4'h0);
            IDX_PF_BASE:    next_rd[15:0] = win_word(pf_base, CAP_32BIT);
            IDX_PF_TOP:     next_rd[15:0] = win_word(pf_top, CAP_32BIT);
            IDX_PF_UPPER:   next_rd[UPPER_W-1:0] = pf_upper;
            IDX_BRIDGE_CTL: next_rd[PERR_EN_BIT] = perr_resp_en;
            IDX_EVT_STATUS: next_rd[EV_W-1:0] = evt_status;
            IDX_EVT_MASK:   next_rd[EV_W-1:0] = evt_mask;
            default:        next_rd = 32'h00000000;
        endcase
    end

    // Acknowledge one cycle after the strobe, every address answered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wr_req || rd_req;
            if (rd_req)
                wb_dat_o <= next_rd;
        end
    end

    // ========================================================================
    // Checks
    devsel_code_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rd_req) && $past(idx) == IDX_SEC_STATUS
        |-> wb_ack_o && wb_dat_o[10:9] == 2'h1)
        else $error("Timing code not medium");

    fixed_bits_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rd_req) && $past(idx) == IDX_SEC_STATUS
        |-> !wb_dat_o[7] && wb_dat_o[5]
            && wb_dat_o[4:0] == 5'h00 && !wb_dat_o[6])
        else $error("Fixed status bits wrong");

    status_reserved_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rd_req) && $past(idx) == IDX_SEC_STATUS
        |-> wb_dat_o[31:11] == 21'h0)
        else $error("Status reserved bits nonzero");

    parity_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(dpe_flag) |-> $past(initiator_i) && $past(perr_resp_en)
            && ($past(perr_seen) || $past(int_parity_err_i)))
        else $error("Parity flag set without cause");

    parity_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_req && idx == IDX_SEC_STATUS && wb_sel_i[1] && wb_dat_i[8]
        && !parity_set |=> !dpe_flag)
        else $error("Parity flag not cleared by one");

    parity_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        dpe_flag && !(wr_req && idx == IDX_SEC_STATUS && wb_sel_i[1]
        && wb_dat_i[8]) |=> dpe_flag)
        else $error("Parity flag lost without a one");

    base_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_req && idx == IDX_NP_BASE && wb_sel_i[1:0] == 2'h3
        |=> np_base == $past(wb_dat_i[15:4]))
        else $error("Base field not written");

    limit_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_req && idx == IDX_NP_LIMIT && wb_sel_i[1:0] == 2'h3
        |=> np_limit == $past(wb_dat_i[15:4]))
        else $error("Limit field not written");

    np_window_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.addr[63:32] == 32'h0
        && req_i.addr[31:20] >= np_base && req_i.addr[31:20] <= np_limit
        |=> dec_valid_o && dec_o.hit_np && dec_o.forward)
        else $error("Window hit not forwarded");

    np_outside_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req_valid_i && (req_i.addr[31:20] < np_base
        || req_i.addr[31:20] > np_limit) |=> !dec_o.hit_np)
        else $error("Outside window hit");

    pf_window_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.addr[31:20] < pf_base
        && req_i.addr[43:32] == pf_upper
        |=> dec_valid_o && !dec_o.hit_pf)
        else $error("Below prefetch base hit");

    pf_inside_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.addr[63:44] == 20'h0
        && req_i.addr[43:32] == pf_upper
        && req_i.addr[31:20] >= pf_base && req_i.addr[31:20] <= pf_top
        |=> dec_valid_o && dec_o.hit_pf && dec_o.forward)
        else $error("Prefetch hit not forwarded");

    cap_bits_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rd_req) && $past(idx) == IDX_PF_BASE
        |-> wb_dat_o[3:0] == 4'h0 && wb_dat_o[31:16] == 16'h0)
        else $error("Capability bits wrong");

    np_reserved_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rd_req) && ($past(idx) == IDX_NP_BASE
        || $past(idx) == IDX_NP_LIMIT)
        |-> wb_dat_o[3:0] == 4'h0)
        else $error("Reserved bits read nonzero");

    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        |(evt_status & evt_mask) ##1 |(evt_status & evt_mask) |-> irq_o)
        else $error("Interrupt not raised");

endmodule // window_decode

// ### window_decode_pkg.sv
// Constants, register map and carriers for the memory window decode bridge
// ============================================================================
// Behaviour
// - Report the slowest secondary decode response in status bits 10:9.
// - That timing field always holds code 01, medium timing.
// - Set status bit 8 when initiator, parity error seen, response enabled.
// - Status bit 7, fast back-to-back, is read-only zero.
// - Status bit 5, 66 MHz capable, is read-only one.
// - Writable status flags clear on a written one; zero leaves them.
// - Non-prefetchable base bits 15:4 hold address bits 31:20, writable.
// - Base decode takes address bits 19:0 as zeros, 1 MB aligned.
// - Non-prefetchable limit bits 15:4 hold address bits 31:20, writable.
// - Limit decode takes address bits 19:0 as all ones.
// - Accesses inside the inclusive base-limit window are forwarded.
// - Prefetchable base bits 15:4 compare with address bits 31:20.
// - Prefetchable base low 20 address bits are zero, 1 MB granularity.
// - Full prefetchable base joins the upper register above the base.
// - Prefetchable base with its limit decides forwarding in that window.
// - Prefetchable base bits 3:0 read-only, report 32-bit addressing.
package window_decode_pkg;

    // ========================================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SEC_STATUS = 8'h1e;
    localparam logic [7:0] IDX_NP_BASE    = 8'h20;
    localparam logic [7:0] IDX_NP_LIMIT   = 8'h22;
    localparam logic [7:0] IDX_PF_BASE    = 8'h24;
    localparam logic [7:0] IDX_PF_TOP     = 8'h26;
    localparam logic [7:0] IDX_PF_UPPER   = 8'h28;
    localparam logic [7:0] IDX_BRIDGE_CTL = 8'h3e;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h40;
    localparam logic [7:0] IDX_EVT_MASK   = 8'h41;

    // ========================================================================
    // Field layout
    localparam int         WIN_LSB       = 4;
    localparam int         WIN_MSB       = 15;
    localparam int         WIN_W         = 12;
    localparam int         UPPER_W       = 12;
    localparam int         GRAN_BITS     = 20;
    localparam int         HUB_ADDR_W    = 64;
    localparam logic [19:0] LOW_ZEROS    = 20'h00000;
    localparam logic [19:0] LOW_ONES     = 20'hfffff;
    localparam logic [19:0] UPPER_PAD    = 20'h00000;
    localparam logic [31:0] HIGH_ZERO    = 32'h00000000;
    localparam logic [3:0] CAP_32BIT     = 4'h0;
    localparam logic [11:0] WIN_RESET    = 12'h000;
    localparam int         DEVSEL_LSB    = 9;
    localparam int         DEVSEL_MSB    = 10;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam int         DPE_BIT       = 8;
    localparam int         FBB_BIT       = 7;
    localparam logic       FBB_VAL       = 1'h0;
    localparam int         CAP66_BIT     = 5;
    localparam logic       CAP66_VAL     = 1'h1;
    localparam int         PERR_EN_BIT   = 0;

    // Interrupt event bits
    localparam int         EV_PARITY = 0;
    localparam int         EV_NP_HIT = 1;
    localparam int         EV_PF_HIT = 2;
    localparam int         EV_MISS   = 3;
    localparam int         EV_W      = 4;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic [HUB_ADDR_W-1:0] addr;
        logic                  write;
    } mem_req_s;

    typedef struct packed {
        logic hit_np;
        logic hit_pf;
        logic forward;
        logic write;
    } mem_dec_s;

endpackage

// ### window_decode_tb.sv
// Self-checking bench for the memory window decode block
`timescale 1ns/1ps

module window_decode_tb
    import window_decode_pkg::*;
;
    localparam logic [9:0] A_ST = {IDX_SEC_STATUS, 2'b00};
    localparam logic [9:0] A_NB = {IDX_NP_BASE, 2'b00};
    localparam logic [9:0] A_NL = {IDX_NP_LIMIT, 2'b00};
    localparam logic [9:0] A_PB = {IDX_PF_BASE, 2'b00};
    localparam logic [9:0] A_PT = {IDX_PF_TOP, 2'b00};
    localparam logic [9:0] A_PU = {IDX_PF_UPPER, 2'b00};
    localparam logic [9:0] A_BC = {IDX_BRIDGE_CTL, 2'b00};
    localparam logic [9:0] A_ES = {IDX_EVT_STATUS, 2'b00};
    localparam logic [9:0] A_EM = {IDX_EVT_MASK, 2'b00};
    localparam logic [9:0] A_UN = 10'h140;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic        req_valid;
    mem_req_s    req;
    logic        dec_valid;
    mem_dec_s    dec;
    logic        initiator;
    logic        perr_n;
    logic        int_perr;
    logic        irq;
    int          errors;
    int          tests_run;

    // ========================================================================
    // Instances
    window_decode dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .req_valid_i(req_valid), .req_i(req), .dec_valid_o(dec_valid),
        .dec_o(dec), .initiator_i(initiator), .perr_n_i(perr_n),
        .int_parity_err_i(int_perr), .irq_o(irq));

    hub_host host (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req),
        .dec_valid_i(dec_valid), .dec_i(dec));

    // Clock, 100 ns period
    always #50 clk_i = ~clk_i;

    // ========================================================================
    // Shared tasks
    task automatic finish_test();
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask

    // Classic Wishbone cycle, held until ack is sampled
    task automatic wb(logic [9:0] a, logic w, logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= 4'h3;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1);
        q = dat_r;
        chk("wb ack cycles", 32'h2, n);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(logic [9:0] a, logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(string n, logic [9:0] a, logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(n, e, q);
    endtask

    // Decode check; code is {hit_np, hit_pf, forward, write}
    task automatic dc(logic [63:0] a, logic w, logic [3:0] e);
        mem_dec_s d;
        logic     ok;
        host.send(a, w, d, ok);
        chk("decode", {27'h0, 1'b1, e}, {27'h0, ok, d});
    endtask

    // Parity sources held for six edges, then quiet
    task automatic pulse(logic i, logic ie, logic pe);
        @(posedge clk_i);
        initiator <= i;
        int_perr  <= ie;
        perr_n    <= ~pe;
        repeat (6) @(posedge clk_i);
        int_perr <= 1'b0;
        perr_n   <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        rd("status", A_ST, 32'h0220);
        rd("np base", A_NB, 32'h0);
        rd("np limit", A_NL, 32'h0);
        rd("pf base", A_PB, 32'h0);
        rd("unmapped", A_UN, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_fields();
        wr(A_ST, 32'hffff);
        rd("status ro", A_ST, 32'h0220);
        wr(A_NB, 32'hffff);
        rd("np base", A_NB, 32'hfff0);
        wr(A_NL, 32'hffff);
        rd("np limit", A_NL, 32'hfff0);
        wr(A_PB, 32'hffff);
        rd("pf base", A_PB, 32'hfff0);
        wr(A_UN, 32'hffff);
        rd("unmapped", A_UN, 32'h0);
    endtask

    task automatic t_np();
        wr(A_NB, 32'h1230);
        wr(A_NL, 32'h1240);
        dc(64'h122fffff, 1'b0, 4'b0000);
        dc(64'h12300000, 1'b1, 4'b1011);
        dc(64'h124fffff, 1'b0, 4'b1010);
        dc(64'h12500000, 1'b0, 4'b0000);
    endtask

    task automatic t_pf();
        wr(A_PB, 32'h2000);
        wr(A_PT, 32'h2100);
        wr(A_PU, 32'h0);
        dc(64'h1fffffff, 1'b0, 4'b0000);
        dc(64'h20000000, 1'b1, 4'b0111);
        dc(64'h210fffff, 1'b0, 4'b0110);
        dc(64'h21100000, 1'b0, 4'b0000);
        wr(A_PU, 32'h1);
        dc(64'h120000000, 1'b0, 4'b0110);
        dc(64'h20000000, 1'b0, 4'b0000);
    endtask

    task automatic t_par();
        wr(A_ES, 32'hf);
        wr(A_BC, 32'h0);
        pulse(1'b1, 1'b1, 1'b0);
        rd("dpe off", A_ST, 32'h0220);
        wr(A_BC, 32'h1);
        pulse(1'b0, 1'b1, 1'b1);
        rd("dpe idle", A_ST, 32'h0220);
        pulse(1'b1, 1'b1, 1'b0);
        rd("dpe int", A_ST, 32'h0320);
        wr(A_ST, 32'h0);
        rd("dpe hold", A_ST, 32'h0320);
        wr(A_ST, 32'h0100);
        rd("dpe clr", A_ST, 32'h0220);
        pulse(1'b1, 1'b0, 1'b1);
        rd("dpe pin", A_ST, 32'h0320);
        wr(A_ST, 32'h0100);
        rd("evt par", A_ES, 32'h1);
    endtask

    task automatic t_irq();
        wr(A_ES, 32'hf);
        rd("evt clr", A_ES, 32'h0);
        wr(A_EM, 32'h2);
        rd("mask", A_EM, 32'h2);
        dc(64'h0, 1'b0, 4'b0000);
        repeat (3) @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        dc(64'h12300000, 1'b0, 4'b1010);
        repeat (3) @(posedge clk_i);
        chk("irq set", 32'h1, {31'h0, irq});
        rd("evt", A_ES, 32'ha);
        wr(A_ES, 32'h2);
        repeat (3) @(posedge clk_i);
        chk("irq clr", 32'h0, {31'h0, irq});
        dc(64'h120000000, 1'b0, 4'b0110);
        rd("evt pf", A_ES, 32'hc);
    endtask

    // ========================================================================
    // Main sequence
    initial
    begin
        clk_i     = 1'b0;
        rst_i     = 1'b1;
        cyc       = 1'b0;
        stb       = 1'b0;
        we        = 1'b0;
        adr       = 10'h0;
        sel       = 4'h0;
        dat_w     = 32'h0;
        initiator = 1'b0;
        perr_n    = 1'b1;
        int_perr  = 1'b0;
        errors    = 0;
        tests_run = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_np();
        t_pf();
        t_par();
        t_irq();
        finish_test();
    end

    // Watchdog against a hang
    initial
    begin
        #2000000;
        errors++;
        finish_test();
    end
endmodule // window_decode_tb
